// ==== hw/dag_pkg.sv ====
`default_nettype none
package dag_pkg;

    localparam int NUM_PTR = 3;

    // APB register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_BANK = 8'h04;
    localparam logic [7:0] OFF_ACC = 8'h08;
    localparam logic [7:0] OFF_PTR0 = 8'h0c;
    localparam logic [7:0] OFF_PTR_STRIDE = 8'h04;
    localparam logic [7:0] OFF_STATUS = 8'h18;
    localparam logic [7:0] OFF_JUMP = 8'h1c;

    // Field positions
    localparam int CTRL_EXT_BIT = 0;
    localparam int STAT_MODE_LSB = 12;
    localparam int STAT_VIRT_BIT = 16;
    localparam int STAT_TOACC_BIT = 17;

    // Reset values
    localparam logic CTRL_EXT_RESET = 1'b0;
    localparam logic [3:0] BANK_RESET = 4'h0;
    localparam logic [7:0] ACC_RESET = 8'h00;
    localparam logic [11:0] PTR_RESET = 12'h000;

    // Access bank split and the upper window it maps to
    localparam logic [7:0] ACCESS_SPLIT = 8'h60;
    localparam logic [3:0] ACCESS_HIGH_BANK = 4'hf;

    // Pointer special registers: block of 8 per pointer
    localparam logic [11:0] VOP_BASE = 12'hfc0;
    localparam logic [2:0] VK_PLAIN = 3'h0;
    localparam logic [2:0] VK_POST_INC = 3'h1;
    localparam logic [2:0] VK_POST_DEC = 3'h2;
    localparam logic [2:0] VK_PRE_INC = 3'h3;
    localparam logic [2:0] VK_ACC_OFS = 3'h4;
    localparam logic [2:0] VK_LOW = 3'h5;
    localparam logic [2:0] VK_HIGH = 3'h6;

    typedef enum logic [2:0] {
        CLS_INHERENT,
        CLS_LITERAL,
        CLS_JUMP,
        CLS_FILE,
        CLS_FULL
    } dag_class_type;

    typedef enum logic [2:0] {
        MODE_NONE,
        MODE_INHERENT,
        MODE_LITERAL,
        MODE_BANKED,
        MODE_ACCESS,
        MODE_FULL,
        MODE_INDIRECT,
        MODE_INDEXED
    } dag_mode_type;

    typedef struct packed {
        logic hit;
        logic [1:0] idx;
        logic [2:0] kind;
    } dag_vop_type;

    function automatic dag_vop_type vop_decode(input logic [11:0] addr);
        dag_vop_type v;
        v.idx = addr[4:3];
        v.kind = addr[2:0];
        v.hit = (addr[11:5] == VOP_BASE[11:5]) && (addr[4:3] != 2'h3)
            && (addr[2:0] != 3'h7);
        return v;
    endfunction

endpackage
`default_nettype wire

// ==== hw/dag_ptr_if.sv ====
`timescale 1ns/10ps
`default_nettype none
interface dag_ptr_if;
    logic [2:0] ld_low;
    logic [2:0] ld_high;
    logic [7:0] ld_data_low;
    logic [7:0] ld_data_high;
    logic [2:0] step_inc;
    logic [2:0] step_dec;
    logic [11:0] value [3];

    modport bank(
        input ld_low,
        input ld_high,
        input ld_data_low,
        input ld_data_high,
        input step_inc,
        input step_dec,
        output value
    );

    modport ctrl(
        output ld_low,
        output ld_high,
        output ld_data_low,
        output ld_data_high,
        output step_inc,
        output step_dec,
        input value
    );
endinterface
`default_nettype wire

// ==== hw/dag_ptr_bank.sv ====
`timescale 1ns/10ps
`default_nettype none
module dag_ptr_bank (
    input wire logic pclk,
    input wire logic presetn,
    dag_ptr_if.bank ptr
);
    genvar n;
    generate
        for (n = 0; n < dag_pkg::NUM_PTR; n++)
        begin : g_ptr
            // Loads beat stepping; the pointer only ever holds 12 bits
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                    ptr.value[n] <= dag_pkg::PTR_RESET;
                else if (ptr.ld_low[n] || ptr.ld_high[n])
                begin
                    if (ptr.ld_low[n])
                        ptr.value[n][7:0] <= ptr.ld_data_low;
                    if (ptr.ld_high[n])
                        ptr.value[n][11:8] <= ptr.ld_data_high[3:0];
                end
                else if (ptr.step_inc[n])
                    ptr.value[n] <= ptr.value[n] + 12'h001;
                else if (ptr.step_dec[n])
                    ptr.value[n] <= ptr.value[n] - 12'h001;
            end
        end
    endgenerate
endmodule
`default_nettype wire

// ==== hw/dag_direct.sv ====
`timescale 1ns/10ps
`default_nettype none
module dag_direct (
    input wire logic [7:0] file_addr,
    input wire logic access,
    input wire logic [3:0] bank,
    input wire logic ext_enable,
    input wire logic [11:0] index_base,
    output logic [11:0] addr,
    output logic indexed
);
    logic low_half;

    always_comb
    begin
        low_half = file_addr < dag_pkg::ACCESS_SPLIT;
        indexed = ext_enable && !access && low_half;
        if (indexed)
            addr = index_base + {4'h0, file_addr};
        else if (access)
            addr = {bank, file_addr};
        else if (low_half)
            addr = {4'h0, file_addr};
        else
            addr = {dag_pkg::ACCESS_HIGH_BANK, file_addr};
    end
endmodule
`default_nettype wire

// ==== hw/dag_top.sv ====
// How it works
// - Opcode low byte selects the operand register
// - Access bit one joins bank and byte
// - Access bit zero selects access bank
// - Full move takes whole address, bank ignored
// - Destination bit picks source register or accumulator
// - No destination bit: fixed implicit target
// - Three pointers, high nibble unused
// - Pointer addresses whole memory linearly
// - Plain operand accesses location pointer names
// - Indirect ignores bank and access bit
// - Post-decrement uses pointer, then subtracts one
// - Post-increment uses pointer, then adds one
// - Pre-increment adds one, then uses pointer
// - Offset operand adds signed accumulator
// - Plain and offset operands change nothing
// - Virtual operands have no storage
// - Pointers reachable as special registers
// - Indexed literal mode only when enabled
// - Jumps carry a 20-bit literal target
`timescale 1ns/10ps
`default_nettype none
module dag_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic op_valid,
    input wire dag_pkg::dag_class_type op_class,
    input wire logic [7:0] op_file,
    input wire logic op_access,
    input wire logic op_has_dest,
    input wire logic op_dest,
    input wire logic op_implicit_acc,
    input wire logic [11:0] op_full_addr,
    input wire logic [19:0] op_literal,
    input wire logic wb_valid,
    input wire logic [7:0] wb_data,
    output logic mem_valid,
    output logic [11:0] mem_addr,
    output dag_pkg::dag_mode_type mem_mode,
    output logic mem_virtual,
    output logic res_to_acc,
    output logic [11:0] res_addr,
    output logic sfr_hit,
    output logic [7:0] sfr_rdata,
    output logic jump_valid,
    output logic [19:0] jump_target,
    output logic [7:0] acc_value
);
    dag_ptr_if ptr ();

    logic ext_enable;
    logic [3:0] bank_select_reg;
    logic [11:0] dir_addr;
    logic dir_indexed;
    logic [11:0] eff_addr;
    dag_pkg::dag_vop_type vop;
    dag_pkg::dag_vop_type wb_vop;
    logic [11:0] sel_ptr;
    logic [11:0] next_addr;
    dag_pkg::dag_mode_type next_mode;
    logic next_virtual;
    logic next_to_acc;
    logic next_sfr_hit;
    logic [7:0] next_sfr_rdata;
    logic apb_setup_done;
    logic apb_wr;
    logic [31:0] next_prdata;
    logic next_pslverr;
    logic [1:0] apb_ptr_idx;
    logic apb_ptr_hit;
    logic file_op;

    dag_ptr_bank u_ptr_bank (
        .pclk(pclk),
        .presetn(presetn),
        .ptr(ptr.bank)
    );

    dag_direct u_direct (
        .file_addr(op_file),
        .access(op_access),
        .bank(bank_select_reg),
        .ext_enable(ext_enable),
        .index_base(ptr.value[2]),
        .addr(dir_addr),
        .indexed(dir_indexed)
    );

    // Operand address resolution
    always_comb
    begin
        file_op = op_class == dag_pkg::CLS_FILE;
        if (op_class == dag_pkg::CLS_FULL)
            eff_addr = op_full_addr;
        else
            eff_addr = dir_addr;
        vop = dag_pkg::vop_decode(eff_addr);
        // Slot 3 of the map has no pointer; keep the mux free of x
        if (vop.idx == 2'h3)
            sel_ptr = 12'h000;
        else
            sel_ptr = ptr.value[vop.idx];
        next_virtual = 1'b0;
        next_addr = eff_addr;
        // Bank and access bit play no part once a pointer is used
        if (vop.hit && vop.kind != dag_pkg::VK_LOW
            && vop.kind != dag_pkg::VK_HIGH)
        begin
            next_virtual = 1'b1;
            case (vop.kind)
                dag_pkg::VK_PRE_INC:
                    next_addr = sel_ptr + 12'h001;
                dag_pkg::VK_ACC_OFS:
                    next_addr = sel_ptr + {{4{acc_value[7]}}, acc_value};
                default:
                    next_addr = sel_ptr;
            endcase
        end
    end

    always_comb
    begin
        next_mode = dag_pkg::MODE_NONE;
        next_to_acc = op_implicit_acc;
        case (op_class)
            dag_pkg::CLS_INHERENT:
                next_mode = dag_pkg::MODE_INHERENT;
            dag_pkg::CLS_LITERAL:
                next_mode = dag_pkg::MODE_LITERAL;
            dag_pkg::CLS_JUMP:
            begin
                next_mode = dag_pkg::MODE_LITERAL;
                next_to_acc = 1'b0;
            end
            dag_pkg::CLS_FILE:
            begin
                if (next_virtual)
                    next_mode = dag_pkg::MODE_INDIRECT;
                else if (dir_indexed)
                    next_mode = dag_pkg::MODE_INDEXED;
                else if (op_access)
                    next_mode = dag_pkg::MODE_BANKED;
                else
                    next_mode = dag_pkg::MODE_ACCESS;
                if (op_has_dest)
                    next_to_acc = !op_dest;
            end
            dag_pkg::CLS_FULL:
            begin
                next_mode = dag_pkg::MODE_FULL;
                next_to_acc = 1'b0;
            end
            default:
                next_mode = dag_pkg::MODE_NONE;
        endcase
    end

    // Pointer halves answer from here, not from the RAM array
    always_comb
    begin
        next_sfr_hit = vop.hit && (vop.kind == dag_pkg::VK_LOW
            || vop.kind == dag_pkg::VK_HIGH);
        if (vop.kind == dag_pkg::VK_HIGH)
            next_sfr_rdata = {4'h0, sel_ptr[11:8]};
        else
            next_sfr_rdata = sel_ptr[7:0];
    end

    // Operand outputs, one cycle after the request
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mem_valid <= 1'b0;
            mem_addr <= 12'h000;
            mem_mode <= dag_pkg::MODE_NONE;
            mem_virtual <= 1'b0;
            res_to_acc <= 1'b0;
            res_addr <= 12'h000;
            sfr_hit <= 1'b0;
            sfr_rdata <= 8'h00;
        end
        else
        begin
            mem_valid <= op_valid && (file_op
                || op_class == dag_pkg::CLS_FULL);
            sfr_hit <= op_valid && (file_op
                || op_class == dag_pkg::CLS_FULL) && next_sfr_hit;
            if (op_valid)
            begin
                mem_addr <= next_addr;
                mem_mode <= next_mode;
                mem_virtual <= next_virtual;
                res_to_acc <= next_to_acc;
                res_addr <= next_addr;
                sfr_rdata <= next_sfr_rdata;
            end
        end
    end

    // Jump target holds until the next jump
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            jump_valid <= 1'b0;
            jump_target <= 20'h00000;
        end
        else
        begin
            jump_valid <= op_valid && op_class == dag_pkg::CLS_JUMP;
            if (op_valid && op_class == dag_pkg::CLS_JUMP)
                jump_target <= op_literal;
        end
    end

    // APB: pready rises one cycle into the access phase
    assign apb_setup_done = psel && penable && !pready;
    assign apb_wr = psel && penable && pready && pwrite;
    assign apb_ptr_hit = paddr >= dag_pkg::OFF_PTR0
        && paddr < dag_pkg::OFF_STATUS && paddr[1:0] == 2'b00;
    assign apb_ptr_idx = 2'((paddr - dag_pkg::OFF_PTR0) >> 2);

    always_comb
    begin
        next_prdata = 32'h00000000;
        next_pslverr = 1'b0;
        if (paddr == dag_pkg::OFF_CTRL)
            next_prdata[dag_pkg::CTRL_EXT_BIT] = ext_enable;
        else if (paddr == dag_pkg::OFF_BANK)
            next_prdata[3:0] = bank_select_reg;
        else if (paddr == dag_pkg::OFF_ACC)
            next_prdata[7:0] = acc_value;
        else if (apb_ptr_hit)
            next_prdata[11:0] = ptr.value[apb_ptr_idx];
        else if (paddr == dag_pkg::OFF_STATUS)
        begin
            next_prdata[11:0] = mem_addr;
            next_prdata[dag_pkg::STAT_MODE_LSB +: 3] = mem_mode;
            next_prdata[dag_pkg::STAT_VIRT_BIT] = mem_virtual;
            next_prdata[dag_pkg::STAT_TOACC_BIT] = res_to_acc;
        end
        else if (paddr == dag_pkg::OFF_JUMP)
            next_prdata[19:0] = jump_target;
        else
            next_pslverr = 1'b1;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
        end
        else
        begin
            pready <= apb_setup_done;
            // Error only stands beside pready, like the rest of the answer
            pslverr <= apb_setup_done && next_pslverr;
            if (apb_setup_done)
            begin
                prdata <= next_prdata;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ext_enable <= dag_pkg::CTRL_EXT_RESET;
            bank_select_reg <= dag_pkg::BANK_RESET;
        end
        else if (apb_wr && paddr == dag_pkg::OFF_CTRL)
            ext_enable <= pwdata[dag_pkg::CTRL_EXT_BIT];
        else if (apb_wr && paddr == dag_pkg::OFF_BANK)
            bank_select_reg <= pwdata[3:0];
    end

    // Datapath write-back outranks software on the accumulator
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            acc_value <= dag_pkg::ACC_RESET;
        else if (wb_valid && res_to_acc)
            acc_value <= wb_data;
        else if (apb_wr && paddr == dag_pkg::OFF_ACC)
            acc_value <= pwdata[7:0];
    end

    // Pointer loads and auto-steps
    assign wb_vop = dag_pkg::vop_decode(res_addr);

    always_comb
    begin
        ptr.ld_low = 3'b000;
        ptr.ld_high = 3'b000;
        ptr.step_inc = 3'b000;
        ptr.step_dec = 3'b000;
        ptr.ld_data_low = wb_data;
        ptr.ld_data_high = wb_data;
        // Virtual operands hold no storage that could be loaded
        if (wb_valid && !res_to_acc && !mem_virtual && wb_vop.hit)
        begin
            if (wb_vop.kind == dag_pkg::VK_LOW)
                ptr.ld_low[wb_vop.idx] = 1'b1;
            else if (wb_vop.kind == dag_pkg::VK_HIGH)
                ptr.ld_high[wb_vop.idx] = 1'b1;
        end
        else if (apb_wr && apb_ptr_hit)
        begin
            ptr.ld_low[apb_ptr_idx] = 1'b1;
            ptr.ld_high[apb_ptr_idx] = 1'b1;
            ptr.ld_data_low = pwdata[7:0];
            ptr.ld_data_high = {4'h0, pwdata[11:8]};
        end
        // Plain and offset operands leave the pointer alone
        if (op_valid && (file_op || op_class == dag_pkg::CLS_FULL)
            && next_virtual)
        begin
            if (vop.kind == dag_pkg::VK_POST_INC
                || vop.kind == dag_pkg::VK_PRE_INC)
                ptr.step_inc[vop.idx] = 1'b1;
            else if (vop.kind == dag_pkg::VK_POST_DEC)
                ptr.step_dec[vop.idx] = 1'b1;
        end
    end
endmodule
`default_nettype wire

// ==== tb/dag_chk.sv ====
`timescale 1ns/10ps
`default_nettype none
module dag_chk (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic op_valid,
    input wire dag_pkg::dag_class_type op_class,
    input wire logic [7:0] op_file,
    input wire logic op_access,
    input wire logic op_has_dest,
    input wire logic op_dest,
    input wire logic op_implicit_acc,
    input wire logic [11:0] op_full_addr,
    input wire logic [19:0] op_literal,
    input wire logic mem_valid,
    input wire logic [11:0] mem_addr,
    input wire dag_pkg::dag_mode_type mem_mode,
    input wire logic res_to_acc,
    input wire logic jump_valid,
    input wire logic [19:0] jump_target
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    wire logic fop = op_valid && op_class == dag_pkg::CLS_FILE;

    // Only the access-bank copies of pointer 0 operands
    sequence s_vop(k);
        fop && !op_access && op_file == k;
    endsequence

    chk_file_low_byte: assert property (
        fop |=> mem_valid && (mem_mode != dag_pkg::MODE_BANKED
        || mem_addr[7:0] == $past(op_file)))
        else $error("operand byte not in address");
    chk_access_upper: assert property (
        fop && !op_access && op_file >= 8'h60 && op_file < 8'hc0
        |=> mem_mode == dag_pkg::MODE_ACCESS
        && mem_addr == {4'hf, $past(op_file)})
        else $error("access bank address wrong");
    chk_full_addr: assert property (
        op_valid && op_class == dag_pkg::CLS_FULL && op_full_addr < 12'hf00
        |=> mem_mode == dag_pkg::MODE_FULL
        && mem_addr == $past(op_full_addr))
        else $error("full move address wrong");
    chk_dest_steer: assert property (
        fop |=> res_to_acc == ($past(op_has_dest) ? !$past(op_dest)
        : $past(op_implicit_acc)))
        else $error("result target wrong");
    chk_jump_target: assert property (
        op_valid && op_class == dag_pkg::CLS_JUMP
        |=> jump_valid && jump_target == $past(op_literal))
        else $error("jump target wrong");
    chk_post_inc: assert property (
        s_vop(8'hc1) ##1 s_vop(8'hc1) |=> mem_addr == $past(mem_addr) + 12'h1)
        else $error("post increment step wrong");
    chk_post_dec: assert property (
        s_vop(8'hc2) ##1 s_vop(8'hc2) |=> mem_addr == $past(mem_addr) - 12'h1)
        else $error("post decrement step wrong");
    chk_offset_keep: assert property (
        s_vop(8'hc4) ##1 s_vop(8'hc4) |=> $stable(mem_addr))
        else $error("offset operand changed state");
endmodule

bind dag_top dag_chk u_chk (.pclk(pclk), .presetn(presetn),
    .op_valid(op_valid), .op_class(op_class), .op_file(op_file),
    .op_access(op_access), .op_has_dest(op_has_dest), .op_dest(op_dest),
    .op_implicit_acc(op_implicit_acc), .op_full_addr(op_full_addr),
    .op_literal(op_literal), .mem_valid(mem_valid), .mem_addr(mem_addr),
    .mem_mode(mem_mode), .res_to_acc(res_to_acc),
    .jump_valid(jump_valid), .jump_target(jump_target));
`default_nettype wire

// ==== tb/dag_ram_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module dag_ram_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic mem_valid,
    input wire logic en,
    input wire logic [2:0] lat,
    input wire logic [7:0] data,
    output logic wb_valid,
    output logic [7:0] wb_data
);
    logic [3:0] cnt;

    // Data toggles outside the pulse so stale values never match
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt <= 4'h0;
            wb_valid <= 1'b0;
            wb_data <= 8'h00;
        end
        else
        begin
            wb_valid <= cnt == 4'h1;
            wb_data <= (cnt == 4'h1) ? data : ~wb_data;
            if (mem_valid && en)
                cnt <= {1'b0, lat} + 4'h1;
            else if (cnt != 4'h0)
                cnt <= cnt - 4'h1;
        end
    end
endmodule
`default_nettype wire

// ==== tb/data_address_generator_test.sv ====
`timescale 1ns/10ps
`default_nettype none
module data_address_generator_test;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, op_valid = 1'b0;
    logic op_access = 1'b0, op_has_dest = 1'b0, op_dest = 1'b0;
    logic op_implicit_acc = 1'b0, wb_en = 1'b0, hd = 1'b0, dd = 1'b0;
    logic ia = 1'b0, pready, pslverr, wb_valid, mem_valid, mem_virtual;
    logic res_to_acc, sfr_hit, jump_valid;
    logic [7:0] paddr = 8'h00, op_file = 8'h00, wb_data, sfr_rdata;
    logic [7:0] acc_value;
    logic [31:0] pwdata = 32'h0, prdata, r = 32'h2e76;
    logic [11:0] op_full_addr = 12'h000, mem_addr, res_addr;
    logic [19:0] op_literal = 20'h0, jump_target;
    dag_pkg::dag_class_type op_class = dag_pkg::CLS_INHERENT;
    dag_pkg::dag_mode_type mem_mode;
    logic [32:0] mq[$], jq[$], rq[$], sq[$];
    int error_cnt = 0, cmp_count = 0;
    logic [7:0] vf[8] = '{8'hc1, 8'hc1, 8'hc2, 8'hc2, 8'hc3, 8'hc4, 8'hc4,
        8'hc0};
    logic [11:0] va[8] = '{12'h100, 12'h101, 12'h102, 12'h101, 12'h101,
        12'h081, 12'h081, 12'h101};

    always #20 pclk = ~pclk;

    dag_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .op_valid, .op_class, .op_file,
        .op_access, .op_has_dest, .op_dest, .op_implicit_acc, .op_full_addr,
        .op_literal, .wb_valid, .wb_data, .mem_valid, .mem_addr, .mem_mode,
        .mem_virtual, .res_to_acc, .res_addr, .sfr_hit, .sfr_rdata,
        .jump_valid, .jump_target, .acc_value);
    dag_ram_model ram (.pclk, .presetn, .mem_valid, .en(wb_en),
        .lat(3'h3), .data(8'h5a), .wb_valid, .wb_data);

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic cmp(input logic [32:0] e, input logic [32:0] g);
        cmp_count++;
        if (g !== e)
        begin
            error_cnt++;
            $display("Error %0t: got %h expected %h", $time, g, e);
        end
    endtask

    task automatic finish_test;
        $display("Compares %0d, errors %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // Empty queue yields x, so an unexpected result always mismatches
    task automatic cmp_mem;
        cmp(mq.size() ? mq.pop_front() : 33'hx, {4'h0, res_addr, mem_mode,
            mem_virtual, res_to_acc, mem_addr});
    endtask

    task automatic cmp_jump;
        cmp(jq.size() ? jq.pop_front() : 33'hx, {13'h0, jump_target});
    endtask

    task automatic cmp_sfr;
        cmp(sq.size() ? sq.pop_front() : 33'hx, {25'h0, sfr_rdata});
    endtask

    task automatic cmp_rd;
        cmp(rq.size() ? rq.pop_front() : 33'hx, {pslverr, prdata});
    endtask

    always @(posedge pclk)
    begin
        if (mem_valid === 1'b1)
            cmp_mem;
        if (jump_valid === 1'b1)
            cmp_jump;
        if (sfr_hit === 1'b1)
            cmp_sfr;
        if (psel && penable && pready === 1'b1 && !pwrite)
            cmp_rd;
    end

    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (n >= 20)
        begin
            error_cnt++;
            finish_test;
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [32:0] e);
        rq.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask

    task automatic op(input dag_pkg::dag_class_type c, input logic [7:0] f,
        input logic a, input logic [19:0] x, input dag_pkg::dag_mode_type m,
        input logic v);
        @(posedge pclk);
        op_valid <= 1'b1;
        op_class <= c;
        op_file <= f;
        op_access <= a;
        op_full_addr <= x[11:0];
        op_literal <= x;
        op_has_dest <= hd;
        op_dest <= dd;
        op_implicit_acc <= ia;
        if (c == dag_pkg::CLS_JUMP)
            jq.push_back({13'h0, x});
        else if (c > dag_pkg::CLS_JUMP)
            mq.push_back({4'h0, x[11:0], m, v, hd ? !dd : ia, x[11:0]});
    endtask

    task automatic op_end;
        @(posedge pclk);
        op_valid <= 1'b0;
    endtask

    initial
    begin
        repeat (20000) @(posedge pclk);
        error_cnt++;
        finish_test;
    end

    initial
    begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        rd(8'h00, 33'h0);
        apb(1'b1, 8'h0c, 32'h0000f100);
        rd(8'h0c, 33'h100);
        apb(1'b1, 8'h08, 32'h80);
        for (int i = 0; i < 8; i++)
            op(dag_pkg::CLS_FILE, vf[i], 1'b0, {8'h0, va[i]},
                dag_pkg::MODE_INDIRECT, 1'b1);
        op_end;
        rd(8'h0c, 33'h101);
        rd(8'h08, 33'h80);
        apb(1'b1, 8'h10, 32'hfff);
        op(dag_pkg::CLS_FILE, 8'hc9, 1'b0, 20'hfff,
            dag_pkg::MODE_INDIRECT, 1'b1);
        op_end;
        rd(8'h10, 33'h0);
        for (int i = 0; i < 4; i++)
        begin
            r = lfsr(r);
            apb(1'b1, 8'h04, {29'h0, r[2:0]});
            op(dag_pkg::CLS_FILE, r[15:8], 1'b1, {9'h0, r[2:0], r[15:8]},
                dag_pkg::MODE_BANKED, 1'b0);
            op_end;
        end
        apb(1'b1, 8'h04, 32'hf);
        op(dag_pkg::CLS_FILE, 8'hc0, 1'b1, 20'h101,
            dag_pkg::MODE_INDIRECT, 1'b1);
        op(dag_pkg::CLS_FULL, 8'h00, 1'b1, 20'h3a5,
            dag_pkg::MODE_FULL, 1'b0);
        op(dag_pkg::CLS_FILE, 8'h80, 1'b0, 20'hf80,
            dag_pkg::MODE_ACCESS, 1'b0);
        hd = 1'b1;
        dd = 1'b1;
        op(dag_pkg::CLS_FILE, 8'h23, 1'b0, 20'h023,
            dag_pkg::MODE_ACCESS, 1'b0);
        dd = 1'b0;
        wb_en <= 1'b1;
        op(dag_pkg::CLS_FILE, 8'h23, 1'b0, 20'h023,
            dag_pkg::MODE_ACCESS, 1'b0);
        op_end;
        repeat (2) @(posedge pclk);
        wb_en <= 1'b0;
        hd = 1'b0;
        ia = 1'b1;
        op(dag_pkg::CLS_FILE, 8'h23, 1'b0, 20'h023,
            dag_pkg::MODE_ACCESS, 1'b0);
        op(dag_pkg::CLS_INHERENT, 8'h00, 1'b0, 20'h0,
            dag_pkg::MODE_NONE, 1'b0);
        op(dag_pkg::CLS_LITERAL, 8'h00, 1'b0, 20'h0,
            dag_pkg::MODE_NONE, 1'b0);
        op(dag_pkg::CLS_JUMP, 8'h00, 1'b0, 20'habcde,
            dag_pkg::MODE_NONE, 1'b0);
        op_end;
        rd(8'h08, 33'h5a);
        rd(8'h1c, 33'habcde);
        sq.push_back(33'h01);
        op(dag_pkg::CLS_FILE, 8'hc5, 1'b0, 20'hfc5,
            dag_pkg::MODE_ACCESS, 1'b0);
        hd = 1'b1;
        dd = 1'b1;
        wb_en <= 1'b1;
        sq.push_back(33'h00);
        op(dag_pkg::CLS_FILE, 8'hce, 1'b0, 20'hfce,
            dag_pkg::MODE_ACCESS, 1'b0);
        op_end;
        repeat (6) @(posedge pclk);
        wb_en <= 1'b0;
        hd = 1'b0;
        rd(8'h10, 33'ha00);
        apb(1'b1, 8'h00, 32'h1);
        apb(1'b1, 8'h14, 32'h200);
        op(dag_pkg::CLS_FILE, 8'h10, 1'b0, 20'h210,
            dag_pkg::MODE_INDEXED, 1'b0);
        op_end;
        apb(1'b1, 8'h00, 32'h0);
        op(dag_pkg::CLS_FILE, 8'h10, 1'b0, 20'h010,
            dag_pkg::MODE_ACCESS, 1'b0);
        op_end;
        rd(8'h18, {15'h0, 1'b1, 1'b0, 1'b0, dag_pkg::MODE_ACCESS,
            12'h010});
        rd(8'h20, {1'b1, 32'h0});
        repeat (5) @(posedge pclk);
        if (mq.size() + jq.size() + rq.size() + sq.size() != 0)
            error_cnt++;
        finish_test;
    end
endmodule
`default_nettype wire
